// >>> hdl/ssr_pkg.sv
package ssr_pkg;

  // ==========================================================
  // widths and field positions
  // ==========================================================
  localparam int unsigned SSR_W        = 16;
  localparam int unsigned SSR_MSB      = 15;
  localparam int unsigned SSR_BYTE_W   = 8;
  localparam int unsigned SSR_WAIT_TRG = 3;

  // status byte bit positions
  localparam int unsigned SSR_STB_ERRQ = 2;
  localparam int unsigned SSR_STB_QUES = 3;
  localparam int unsigned SSR_STB_MAV  = 4;
  localparam int unsigned SSR_STB_ESB  = 5;
  localparam int unsigned SSR_STB_RQS  = 6;
  localparam int unsigned SSR_STB_OPER = 7;

  // ==========================================================
  // register select codes for the query port
  // ==========================================================
  localparam logic [3:0] SSR_SEL_COND = 4'h0;
  localparam logic [3:0] SSR_SEL_RISE = 4'h1;
  localparam logic [3:0] SSR_SEL_FALL = 4'h2;
  localparam logic [3:0] SSR_SEL_EVNT = 4'h3;
  localparam logic [3:0] SSR_SEL_MASK = 4'h4;

  // register group codes
  localparam logic [2:0] SSR_GRP_OPER = 3'h0;
  localparam logic [2:0] SSR_GRP_QUES = 3'h1;
  localparam logic [2:0] SSR_GRP_STD  = 3'h2;
  localparam logic [2:0] SSR_GRP_TOP  = 3'h3;
  localparam logic [2:0] SSR_GRP_PPM  = 3'h4;

  // reset values
  localparam logic [15:0] SSR_RST_RISE = 16'h7FFF;
  localparam logic [15:0] SSR_RST_ZERO = 16'h0000;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  grp;
    logic [3:0]  sel;
    logic [15:0] wdata;
  } ssr_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } ssr_rsp_t;

endpackage : ssr_pkg

// >>> hdl/ssr_part.sv
`timescale 1ns/1ns
// one five-part 16-bit status register
module ssr_part
  import ssr_pkg::*;
#(
  parameter int unsigned W = SSR_W
)(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // live conditions
  input  wire logic [W-1:0] cond_i,
  // controller access
  input  wire logic         wr_rise_i,
  input  wire logic         wr_fall_i,
  input  wire logic         wr_mask_i,
  input  wire logic         rd_evnt_i,
  input  wire logic [W-1:0] wdata_i,
  // register contents
  output logic      [W-1:0] cond_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o,
  output logic      [W-1:0] evnt_o,
  output logic      [W-1:0] mask_o,
  output logic              sum_o
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic [W-1:0] evnt;
    logic [W-1:0] mask;
  } ssr_part_st_t;

  ssr_part_st_t st;
  ssr_part_st_t next_st;
  logic [W-1:0] cond_m;
  logic [W-1:0] hits;
  logic [W-1:0] top_zero;

  // top bit forced low so parts read as positive integers
  assign top_zero = {1'b0, {(W-1){1'b1}}};
  assign cond_m   = cond_i & top_zero;

  // ==========================================================
  // edge filtering into the event latch
  // ==========================================================
  always_comb
  begin
    next_st      = st;
    next_st.prev = cond_m;
    hits = (cond_m & ~st.prev & st.rise)
         | (~cond_m & st.prev & st.fall);
    // read clears, but a fresh edge in that cycle survives
    if (rd_evnt_i)
      next_st.evnt = hits;
    else
      next_st.evnt = st.evnt | hits;
    if (wr_rise_i)
      next_st.rise = wdata_i & top_zero;
    if (wr_fall_i)
      next_st.fall = wdata_i & top_zero;
    if (wr_mask_i)
      next_st.mask = wdata_i & top_zero;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st.prev <= '0;
      st.rise <= SSR_RST_RISE[W-1:0];
      st.fall <= SSR_RST_ZERO[W-1:0];
      st.evnt <= '0;
      st.mask <= SSR_RST_ZERO[W-1:0];
    end
    else
      st <= next_st;
  end

  // condition part is the live input, never stored or written
  assign cond_o = cond_m;
  assign rise_o = st.rise;
  assign fall_o = st.fall;
  assign evnt_o = st.evnt;
  assign mask_o = st.mask;
  assign sum_o  = |(st.evnt & st.mask);

endmodule : ssr_part

// >>> hdl/ssr_hier.sv
`timescale 1ns/1ns
// Contract
// - five parts, 16 bits, shared bit positions
// - bit 15 of every part reads zero
// - operation bit 3 is waiting-for-trigger
// - live part follows hardware or lower summary
// - live part read-only, reads don't change
// - rising edge sets event if filter set
// - falling edge sets event if filter set
// - edge filters freely readable and writable
// - event part latches, read returns then clears
// - events set only through filters, continuously
// - summary is OR of event AND mask
// - enable mask freely readable and writable
// - summary feeds next higher live part
// - request mask and standard mask act as enables
// - status byte gathers three register summaries
// - message-available bit shows output buffer data
// - individual flag selected by parallel poll mask
// - all registers and error queue are readable; the error queue here only sets status bit 2
// - request on masked rise, mask bit 6 ignored
// - individual flag ORs byte AND mask, bit 6 in
module ssr_hier
  import ssr_pkg::*;
#(
  parameter int unsigned W = SSR_W
)(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // hardware conditions (asynchronous)
  input  wire logic [W-1:0] oper_cond_i,
  input  wire logic [W-1:0] ques_cond_i,
  input  wire logic         wait_trig_i,
  // standard event pulses from the command engine
  input  wire logic [7:0]   std_event_i,
  // output buffer and error queue state
  input  wire logic         out_buf_avail_i,
  input  wire logic         err_queue_avail_i,
  // controller query port
  input  wire ssr_req_t     req_i,
  output ssr_rsp_t          rsp_o,
  // status byte, service request and individual flag
  output logic [7:0]        top_status_byte_o,
  output logic              service_req_o,
  output logic              individual_status_flag_o
);

  typedef struct packed {
    logic [W-1:0] oper_s1;
    logic [W-1:0] oper_s2;
    logic [W-1:0] ques_s1;
    logic [W-1:0] ques_s2;
    logic         trig_s1;
    logic         trig_s2;
    logic [7:0]   std_evt;
    logic [7:0]   std_mask;
    logic [7:0]   srq_mask;
    logic [7:0]   ppoll_mask;
    logic [7:0]   stb_prev;
    logic         srq;
    logic         rsp_valid;
    logic [15:0]  rsp_data;
  } ssr_hier_st_t;

  ssr_hier_st_t st;
  ssr_hier_st_t next_st;

  logic [W-1:0] oper_cond;
  logic [W-1:0] oper_rise;
  logic [W-1:0] oper_fall;
  logic [W-1:0] oper_evnt;
  logic [W-1:0] oper_mask;
  logic         oper_sum;
  logic [W-1:0] ques_cond;
  logic [W-1:0] ques_rise;
  logic [W-1:0] ques_fall;
  logic [W-1:0] ques_evnt;
  logic [W-1:0] ques_mask;
  logic         ques_sum;
  logic [W-1:0] oper_in;
  logic         std_sum;
  logic [7:0]   stb_base;
  logic [7:0]   stb;
  logic         wr_oper;
  logic         wr_ques;
  logic         rd_oper;
  logic         rd_ques;
  logic         std_rd;

  // ==========================================================
  // operation conditions with waiting-for-trigger on bit 3
  // ==========================================================
  always_comb
  begin
    oper_in               = st.oper_s2;
    oper_in[SSR_WAIT_TRG] = st.trig_s2;
  end

  // access strobes per register group
  assign wr_oper = req_i.wr && (req_i.grp == SSR_GRP_OPER);
  assign wr_ques = req_i.wr && (req_i.grp == SSR_GRP_QUES);
  assign rd_oper = req_i.rd && (req_i.grp == SSR_GRP_OPER)
                   && (req_i.sel == SSR_SEL_EVNT);
  assign rd_ques = req_i.rd && (req_i.grp == SSR_GRP_QUES)
                   && (req_i.sel == SSR_SEL_EVNT);
  assign std_rd  = req_i.rd && (req_i.grp == SSR_GRP_STD)
                   && (req_i.sel == SSR_SEL_EVNT);

  // ==========================================================
  // the two scpi five-part registers
  // ==========================================================
  ssr_part #(.W(W)) u_oper (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .cond_i    (oper_in),
    .wr_rise_i (wr_oper && (req_i.sel == SSR_SEL_RISE)),
    .wr_fall_i (wr_oper && (req_i.sel == SSR_SEL_FALL)),
    .wr_mask_i (wr_oper && (req_i.sel == SSR_SEL_MASK)),
    .rd_evnt_i (rd_oper),
    .wdata_i   (req_i.wdata[W-1:0]),
    .cond_o    (oper_cond),
    .rise_o    (oper_rise),
    .fall_o    (oper_fall),
    .evnt_o    (oper_evnt),
    .mask_o    (oper_mask),
    .sum_o     (oper_sum)
  );

  ssr_part #(.W(W)) u_ques (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .cond_i    (st.ques_s2),
    .wr_rise_i (wr_ques && (req_i.sel == SSR_SEL_RISE)),
    .wr_fall_i (wr_ques && (req_i.sel == SSR_SEL_FALL)),
    .wr_mask_i (wr_ques && (req_i.sel == SSR_SEL_MASK)),
    .rd_evnt_i (rd_ques),
    .wdata_i   (req_i.wdata[W-1:0]),
    .cond_o    (ques_cond),
    .rise_o    (ques_rise),
    .fall_o    (ques_fall),
    .evnt_o    (ques_evnt),
    .mask_o    (ques_mask),
    .sum_o     (ques_sum)
  );

  // ==========================================================
  // status byte assembly
  // ==========================================================
  assign std_sum = |(st.std_evt & st.std_mask);

  always_comb
  begin
    stb_base = '0;
    stb_base[SSR_STB_ERRQ] = err_queue_avail_i;
    stb_base[SSR_STB_QUES] = ques_sum;
    stb_base[SSR_STB_MAV]  = out_buf_avail_i;
    stb_base[SSR_STB_ESB]  = std_sum;
    stb_base[SSR_STB_OPER] = oper_sum;
    stb = stb_base;
    // summary bit 6 covers the others, so its own mask is dropped
    stb[SSR_STB_RQS] = |(stb_base & st.srq_mask
                         & ~(8'h01 << SSR_STB_RQS));
  end

  // ==========================================================
  // next state: sync, std events, masks, request, query answers
  // ==========================================================
  always_comb
  begin
    next_st           = st;
    // two-flop capture of pin conditions
    next_st.oper_s1   = oper_cond_i;
    next_st.oper_s2   = st.oper_s1;
    next_st.ques_s1   = ques_cond_i;
    next_st.ques_s2   = st.ques_s1;
    next_st.trig_s1   = wait_trig_i;
    next_st.trig_s2   = st.trig_s1;
    // standard events: new pulses win over read clear
    if (std_rd)
      next_st.std_evt = std_event_i;
    else
      next_st.std_evt = st.std_evt | std_event_i;
    if (req_i.wr && (req_i.sel == SSR_SEL_MASK))
    begin
      unique case (req_i.grp)
        SSR_GRP_STD: next_st.std_mask   = req_i.wdata[7:0];
        SSR_GRP_TOP: next_st.srq_mask   = req_i.wdata[7:0];
        SSR_GRP_PPM: next_st.ppoll_mask = req_i.wdata[7:0];
        default: ;
      endcase
    end
    // request on a masked rise of any bit except 6
    next_st.stb_prev = stb;
    if (|(stb & ~st.stb_prev & st.srq_mask
          & ~(8'h01 << SSR_STB_RQS)))
      next_st.srq = 1'b1;
    else if (!stb[SSR_STB_RQS])
      next_st.srq = 1'b0;
    // registered answer, one cycle after a read
    next_st.rsp_valid = req_i.rd;
    next_st.rsp_data  = '0;
    unique case (req_i.grp)
      SSR_GRP_OPER:
        unique case (req_i.sel)
          SSR_SEL_COND: next_st.rsp_data = oper_cond;
          SSR_SEL_RISE: next_st.rsp_data = oper_rise;
          SSR_SEL_FALL: next_st.rsp_data = oper_fall;
          SSR_SEL_EVNT: next_st.rsp_data = oper_evnt;
          SSR_SEL_MASK: next_st.rsp_data = oper_mask;
          default: ;
        endcase
      SSR_GRP_QUES:
        unique case (req_i.sel)
          SSR_SEL_COND: next_st.rsp_data = ques_cond;
          SSR_SEL_RISE: next_st.rsp_data = ques_rise;
          SSR_SEL_FALL: next_st.rsp_data = ques_fall;
          SSR_SEL_EVNT: next_st.rsp_data = ques_evnt;
          SSR_SEL_MASK: next_st.rsp_data = ques_mask;
          default: ;
        endcase
      SSR_GRP_STD:
        if (req_i.sel == SSR_SEL_EVNT)
          next_st.rsp_data = {8'h00, st.std_evt};
        else if (req_i.sel == SSR_SEL_MASK)
          next_st.rsp_data = {8'h00, st.std_mask};
      SSR_GRP_TOP:
        if (req_i.sel == SSR_SEL_MASK)
          next_st.rsp_data = {8'h00, st.srq_mask};
        else
          next_st.rsp_data = {8'h00, stb};
      SSR_GRP_PPM:
        next_st.rsp_data = {8'h00, st.ppoll_mask};
      default: ;
    endcase
    if (!req_i.rd)
      next_st.rsp_data = st.rsp_data;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st.oper_s1    <= '0;
      st.oper_s2    <= '0;
      st.ques_s1    <= '0;
      st.ques_s2    <= '0;
      st.trig_s1    <= 1'b0;
      st.trig_s2    <= 1'b0;
      st.std_evt    <= 8'h00;
      st.std_mask   <= 8'h00;
      st.srq_mask   <= 8'h00;
      st.ppoll_mask <= 8'h00;
      st.stb_prev   <= 8'h00;
      st.srq        <= 1'b0;
      st.rsp_valid  <= 1'b0;
      st.rsp_data   <= SSR_RST_ZERO;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign rsp_o.valid       = st.rsp_valid;
  assign rsp_o.rdata       = st.rsp_data;
  assign top_status_byte_o = stb;
  assign service_req_o     = st.srq;
  // flag uses bit 6 too, unlike the request mask
  assign individual_status_flag_o =
           |(stb & st.ppoll_mask);

endmodule : ssr_hier

// >>> verification/ssr_ctl.sv
`timescale 1ns/1ns
// remote controller issuing queries and settings
module ssr_ctl
  import ssr_pkg::*;
(
  // clock
  input  wire logic mclk_i,
  // query port toward the device
  output ssr_req_t  req_o
);
  // idle until the bench asks for a transfer
  initial req_o = '0;

  // one request, held across the edge that takes it
  task xfer(input logic r, input logic w, input logic [2:0] g,
            input logic [3:0] s, input logic [15:0] d);
    @(posedge mclk_i);
    #1;
    req_o <= '{rd: r, wr: w, grp: g, sel: s, wdata: d};
    @(posedge mclk_i);
    #1;
    // released lines must not look like stale data
    req_o <= '{rd: 1'b0, wr: 1'b0, grp: ~g, sel: ~s, wdata: ~d};
  endtask : xfer
endmodule : ssr_ctl

// >>> verification/ssr_hier_asserts.sv
`timescale 1ns/1ns
module ssr_hier_asserts
  import ssr_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // watched inputs
  input  wire logic       out_buf_avail_i,
  input  wire logic       err_queue_avail_i,
  input  wire ssr_req_t   req_i,
  // watched outputs
  input  wire ssr_rsp_t   rsp_o,
  input  wire logic [7:0] top_status_byte_o,
  input  wire logic       service_req_o,
  input  wire logic       individual_status_flag_o
);
  logic [7:0] srm;
  logic [7:0] ppm;

  // shadow top masks from writes; masks are not visible at the ports
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      srm <= 8'h00;
      ppm <= 8'h00;
    end
    else if (req_i.wr)
    begin
      if (req_i.grp == SSR_GRP_TOP && req_i.sel == SSR_SEL_MASK)
        srm <= req_i.wdata[7:0];
      if (req_i.grp == SSR_GRP_PPM && req_i.sel == SSR_SEL_MASK)
        ppm <= req_i.wdata[7:0];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // query port
  // ==========================================================
  a_msb_zero: assert property (
    rsp_o.valid |-> !rsp_o.rdata[SSR_MSB])
    else $error("answer has top bit set");
  a_read_answer: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read got no answer");
  a_no_stray: assert property (!req_i.rd |=> !rsp_o.valid)
    else $error("answer without read");
  a_rdata_hold: assert property (
    !rsp_o.valid |-> $stable(rsp_o.rdata))
    else $error("read data moved between answers");

  // ==========================================================
  // status byte, request and flag
  // ==========================================================
  a_mav_bit: assert property (
    top_status_byte_o[SSR_STB_MAV] == out_buf_avail_i)
    else $error("message bit wrong");
  a_errq_bit: assert property (
    top_status_byte_o[SSR_STB_ERRQ] == err_queue_avail_i)
    else $error("error queue bit wrong");
  a_req_sum: assert property (
    top_status_byte_o[SSR_STB_RQS] ==
      |(top_status_byte_o & srm & 8'hBF))
    else $error("request summary wrong");
  a_flag_sum: assert property (
    individual_status_flag_o == |(top_status_byte_o & ppm))
    else $error("individual flag wrong");
  a_srq_cause: assert property (
    $rose(service_req_o) |-> $past(top_status_byte_o[SSR_STB_RQS]))
    else $error("request without cause");
  a_srq_clear: assert property (
    !top_status_byte_o[SSR_STB_RQS] ##1 !top_status_byte_o[SSR_STB_RQS]
      |-> !service_req_o)
    else $error("request not withdrawn");
endmodule : ssr_hier_asserts

bind ssr_hier ssr_hier_asserts chk (
  .mclk_i                   (mclk_i),
  .rst_n_i                  (rst_n_i),
  .out_buf_avail_i          (out_buf_avail_i),
  .err_queue_avail_i        (err_queue_avail_i),
  .req_i                    (req_i),
  .rsp_o                    (rsp_o),
  .top_status_byte_o        (top_status_byte_o),
  .service_req_o            (service_req_o),
  .individual_status_flag_o (individual_status_flag_o)
);

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb
  import ssr_pkg::*;
;
  // ==========================================================
  // signals
  // ==========================================================
  logic        mclk_i            = 1'b0;
  logic        rst_n_i           = 1'b0;
  logic [15:0] oper_cond_i       = 16'h0000;
  logic [15:0] ques_cond_i       = 16'h0000;
  logic        wait_trig_i       = 1'b0;
  logic [7:0]  std_event_i       = 8'h00;
  logic        out_buf_avail_i   = 1'b0;
  logic        err_queue_avail_i = 1'b0;
  ssr_req_t    req_i;
  ssr_rsp_t    rsp_o;
  logic [7:0]  top;
  logic        srq;
  logic        individual_status_flag;
  logic [15:0] exp_q[$];
  int          fails      = 0;
  int          num_checks = 0;
  logic [15:0] rv, fv, pv, cv, ev;

  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  ssr_hier dut (
    .mclk_i                   (mclk_i),
    .rst_n_i                  (rst_n_i),
    .oper_cond_i              (oper_cond_i),
    .ques_cond_i              (ques_cond_i),
    .wait_trig_i              (wait_trig_i),
    .std_event_i              (std_event_i),
    .out_buf_avail_i          (out_buf_avail_i),
    .err_queue_avail_i        (err_queue_avail_i),
    .req_i                    (req_i),
    .rsp_o                    (rsp_o),
    .top_status_byte_o        (top),
    .service_req_o            (srq),
    .individual_status_flag_o (individual_status_flag)
  );

  ssr_ctl ctl (
    .mclk_i (mclk_i),
    .req_o  (req_i)
  );

  // ==========================================================
  // tasks
  // ==========================================================
  task check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  // expectation is noted before the query leaves
  task rd(input logic [2:0] g, input logic [3:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    ctl.xfer(1'b1, 1'b0, g, s, 16'h0000);
  endtask : rd

  task wr(input logic [2:0] g, input logic [3:0] s, input logic [15:0] d);
    ctl.xfer(1'b0, 1'b1, g, s, d);
  endtask : wr

  // ends just after an edge so pin changes stay off it
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task close_out;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // answers are judged at the falling edge, when settled
  always @(negedge mclk_i)
  begin
    if (rsp_o.valid === 1'b1)
    begin
      check({15'h0000, exp_q.size() != 0}, 16'h0001);
      if (exp_q.size() != 0)
        check(rsp_o.rdata, exp_q.pop_front());
    end
  end

  // hang guard, generous against a few hundred cycles of work
  initial
  begin
    #200000;
    fails++;
    close_out();
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    rv = 16'($urandom(32'hFF10A682));
    cyc(4);
    rst_n_i = 1'b1;
    // reset contents of both detailed registers
    for (int g = 0; g < 2; g++)
    begin
      rd(3'(g), SSR_SEL_RISE, SSR_RST_RISE);
      rd(3'(g), SSR_SEL_FALL, 16'h0000);
      rd(3'(g), SSR_SEL_EVNT, 16'h0000);
      rd(3'(g), SSR_SEL_MASK, 16'h0000);
    end
    // live and event parts refuse writes; others keep them
    for (int s = 0; s < 5; s++)
    begin
      rv = 16'($urandom());
      wr(SSR_GRP_OPER, 4'(s), rv);
      pv = (s == 0 || s == 3) ? 16'h0000 : rv & 16'h7FFF;
      rd(SSR_GRP_OPER, 4'(s), pv);
      rd(SSR_GRP_OPER, 4'(s), pv);
    end
    rd(3'h5, 4'h0, 16'h0000);
    // random transitions through random filters
    rv = 16'($urandom());
    fv = 16'($urandom());
    wr(SSR_GRP_QUES, SSR_SEL_RISE, rv);
    wr(SSR_GRP_QUES, SSR_SEL_FALL, fv);
    wr(SSR_GRP_QUES, SSR_SEL_MASK, 16'h7FFF);
    pv = 16'h0000;
    for (int i = 0; i < 6; i++)
    begin
      cv = 16'($urandom());
      ques_cond_i = cv;
      ev = (cv & ~pv & rv) | (pv & ~cv & fv);
      ev = ev & 16'h7FFF;
      cyc(5);
      check(16'(top[SSR_STB_QUES]), 16'(|ev));
      rd(SSR_GRP_QUES, SSR_SEL_COND, cv & 16'h7FFF);
      rd(SSR_GRP_QUES, SSR_SEL_EVNT, ev);
      rd(SSR_GRP_QUES, SSR_SEL_EVNT, 16'h0000);
      pv = cv;
    end
    // waiting-for-trigger takes bit 3 of the operation register
    wr(SSR_GRP_OPER, SSR_SEL_RISE, 16'h0008);
    wr(SSR_GRP_OPER, SSR_SEL_FALL, 16'h0000);
    wr(SSR_GRP_OPER, SSR_SEL_MASK, 16'h0008);
    oper_cond_i = 16'hFFFF;
    cyc(5);
    rd(SSR_GRP_OPER, SSR_SEL_COND, 16'h7FF7);
    check(16'(top[SSR_STB_OPER]), 16'h0000);
    wait_trig_i = 1'b1;
    cyc(5);
    rd(SSR_GRP_OPER, SSR_SEL_COND, 16'h7FFF);
    check(16'(top[SSR_STB_OPER]), 16'h0001);
    rd(SSR_GRP_OPER, SSR_SEL_EVNT, 16'h0008);
    cyc(2);
    check(16'(top[SSR_STB_OPER]), 16'h0000);
    // fresh rise lands on the edge that reads and clears the event part
    wait_trig_i = 1'b0;
    cyc(5);
    wait_trig_i = 1'b1;
    cyc(1);
    rd(SSR_GRP_OPER, SSR_SEL_EVNT, 16'h0000);
    rd(SSR_GRP_OPER, SSR_SEL_EVNT, 16'h0008);
    // standard event reaches request and flag
    wr(SSR_GRP_TOP, SSR_SEL_MASK, 16'h0060);
    wr(SSR_GRP_STD, SSR_SEL_MASK, 16'h0004);
    wr(SSR_GRP_PPM, SSR_SEL_MASK, 16'h0020);
    std_event_i = 8'h04;
    cyc(1);
    std_event_i = 8'h00;
    cyc(2);
    check(16'(top[SSR_STB_ESB]), 16'h0001);
    check(16'(srq), 16'h0001);
    check(16'(individual_status_flag), 16'h0001);
    // a new event landing on the read edge must survive the clear
    fork
      rd(SSR_GRP_STD, SSR_SEL_EVNT, 16'h0004);
      begin
        cyc(1);
        std_event_i = 8'h01;
        cyc(1);
        std_event_i = 8'h00;
      end
    join
    cyc(2);
    check(16'(srq), 16'h0000);
    check(16'(individual_status_flag), 16'h0000);
    rd(SSR_GRP_STD, SSR_SEL_EVNT, 16'h0001);
    // bit 6 is ignored by the request mask, used by the poll mask
    wr(SSR_GRP_TOP, SSR_SEL_MASK, 16'h0050);
    wr(SSR_GRP_PPM, SSR_SEL_MASK, 16'h0040);
    out_buf_avail_i = 1'b1;
    err_queue_avail_i = 1'b1;
    cyc(2);
    check({8'h00, top}, 16'h0054);
    check(16'(srq), 16'h0001);
    check(16'(individual_status_flag), 16'h0001);
    rd(SSR_GRP_TOP, SSR_SEL_COND, 16'h0054);
    rd(SSR_GRP_TOP, SSR_SEL_MASK, 16'h0050);
    rd(SSR_GRP_STD, SSR_SEL_MASK, 16'h0004);
    rd(SSR_GRP_PPM, SSR_SEL_COND, 16'h0040);
    out_buf_avail_i = 1'b0;
    cyc(3);
    check(16'(srq), 16'h0000);
    check({15'h0000, exp_q.size() == 0}, 16'h0001);
    close_out();
  end
endmodule : tb
